// ---- hw/sfpc_pkg.sv ----
// shared constants for the synthesizer frequency and power_index_limit control block
package sfpc_pkg;
    localparam int unsigned CLK_HZ            = 25_000_000;
    localparam int unsigned BASE_W            = 24;
    localparam int unsigned CHAN_W            = 8;
    localparam int unsigned MANT_W            = 8;
    localparam int unsigned EXP_W             = 2;
    localparam int unsigned PIDX_W            = 3;
    localparam int unsigned PWR_W             = 8;
    localparam int unsigned TABLE_DEPTH       = 8;
    localparam logic [8:0]  SPACING_OFFSET    = 9'h100;
    localparam int unsigned EXP_BIAS          = 2;
    localparam int unsigned CAL_CRYSTAL_OSCILLATOR_PERIODS  = 18739;
    localparam int unsigned CAL_CYCLES        = CAL_CRYSTAL_OSCILLATOR_PERIODS;
    localparam int unsigned CAL_W             = 15;
    localparam int unsigned SHAPE_DIV         = 8;
    localparam int unsigned SYM_DIV_W         = 16;
    localparam logic [PWR_W-1:0]  PWR_RESET   = 8'hC6;
    localparam logic [PIDX_W-1:0] PIDX_RESET  = 3'h0;
    localparam logic [1:0]  AUTOCAL_NEVER     = 2'h0;
    localparam logic [1:0]  AUTOCAL_ON        = 2'h1;
    localparam logic [1:0]  AUTOCAL_OFF       = 2'h2;
    localparam logic [1:0]  AUTOCAL_OFF4      = 2'h3;
    localparam logic [1:0]  AUTOCAL_RESET     = AUTOCAL_ON;
    typedef enum logic [2:0] {
        SFPC_SLEEP, SFPC_IDLE, SFPC_CAL_ON, SFPC_TX, SFPC_RAMP_DN, SFPC_CAL_OFF, SFPC_CAL_MAN
    } sfpc_state_t;
endpackage

// ---- hw/sfpc_core.sv ----
// synthesizer frequency word, calibration sequencing and power_index_limit level selection
`timescale 1ns/100ps
// How it works
// - channel spacing comes from a mantissa field and an exponent field
// - base frequency is 24 bits from high, middle and low byte ports
// - 8-bit channel number times spacing step added to the base word
// - word = base + chan*((256+mant) << exp) >> 2, scaled by crystal/2^16
// - autocal selection calibrates when synthesizer switches on or off
// - after reset autocal selects calibrate on switch-on
// - manual calibrate strobe starts calibration only while idle
// - sleep loses calibration; host recalibrates before transmit
// - chip select low powers the core; ready low before serial use
// - after power-down strobe, chip select high sleeps, low wakes again
// - eight-entry power table with a 3-bit power index limit
// - ramping and shaping walk table entries 0 up to the index limit
// - index limit zero uses entry zero only, no ramping
// - table entries default to 0xC6 after reset
// - amplitude shaping counter counts up on one, down on zero
// - shaping counter steps at eight times the symbol rate
// - shaping counter saturates at index limit and zero, indexes table
// - autocal may calibrate on every fourth transmit to idle
// - one calibration takes 18739 crystal clock periods
module sfpc_core
    import sfpc_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  chip_select_n_in,
    input  wire logic                  soft_reset_strobe_in,
    input  wire logic                  power_down_strobe_in,
    input  wire logic                  calibrate_strobe_in,
    input  wire logic                  tx_strobe_in,
    input  wire logic                  idle_strobe_in,
    input  wire logic                  packet_end_in,
    input  wire logic [7:0]            base_base_frequency_word_high_byte_in,
    input  wire logic [7:0]            base_base_frequency_word_mid_byte_in,
    input  wire logic [7:0]            base_base_frequency_word_low_byte_in,
    input  wire logic [CHAN_W-1:0]     channel_number_in,
    input  wire logic [MANT_W-1:0]     spacing_mantissa_in,
    input  wire logic [EXP_W-1:0]      spacing_exponent_in,
    input  wire logic [1:0]            synth_autocal_select_in,
    input  wire logic                  autocal_write_in,
    input  wire logic [PIDX_W-1:0]     power_index_limit_in,
    input  wire logic                  power_index_write_in,
    input  wire logic                  table_write_in,
    input  wire logic [PIDX_W-1:0]     table_addr_in,
    input  wire logic [PWR_W-1:0]      table_data_in,
    input  wire logic                  ask_mode_in,
    input  wire logic                  symbol_in,
    input  wire logic [SYM_DIV_W-1:0]  shape_tick_div_in,
    output logic                       chip_ready_n_out,
    output logic                       core_power_out,
    output logic                       synth_on_out,
    output logic                       calibrating_out,
    output logic                       calibrated_out,
    output logic                       pa_on_out,
    output logic [BASE_W-1:0]          synth_base_frequency_word_word_out,
    output logic [PIDX_W-1:0]          pa_index_out,
    output logic [PWR_W-1:0]           pa_level_out,
    output logic [1:0]                 autocal_select_out
);
    // ==========================================================
    // frequency word
    function automatic logic [BASE_W-1:0] base_frequency_word_word(
        input logic [BASE_W-1:0] base,
        input logic [CHAN_W-1:0] chan,
        input logic [MANT_W-1:0] mant,
        input logic [EXP_W-1:0]  expo
    );
        logic [BASE_W+1:0] step4;
        logic [BASE_W+1:0] prod4;
        // step in quarter units keeps the 2^-2 exact
        step4 = ((BASE_W+2)'(SPACING_OFFSET) + (BASE_W+2)'(mant)) << expo;
        prod4 = (BASE_W+2)'(step4 * (BASE_W+2)'(chan));
        base_frequency_word_word = base + prod4[BASE_W+1:EXP_BIAS];
    endfunction

    logic [BASE_W-1:0] base_frequency_word;
    assign base_frequency_word = {base_base_frequency_word_high_byte_in, base_base_frequency_word_mid_byte_in,
                                  base_base_frequency_word_low_byte_in};

    // ==========================================================
    // power state and control
    sfpc_state_t       state;
    logic              pd_armed;
    logic [CAL_W-1:0]  cal_cnt;
    logic [1:0]        tx_off_cnt;
    logic [PIDX_W-1:0] shape_idx;
    logic [SYM_DIV_W-1:0] tick_cnt;
    logic              tick;
    logic [PWR_W-1:0]  power_level_table [TABLE_DEPTH];
    logic [PIDX_W-1:0] power_index_limit;
    logic              cal_done;
    logic              soft_rst;

    assign cal_done = (cal_cnt == CAL_W'(CAL_CYCLES - 1));
    assign soft_rst = soft_reset_strobe_in && !chip_select_n_in;

    // cal states share one decode for the flags below
    function automatic logic is_cal(input sfpc_state_t s);
        is_cal = (s == SFPC_CAL_ON) || (s == SFPC_CAL_OFF) || (s == SFPC_CAL_MAN);
    endfunction

    // autocal selection, back to its reset value on soft reset and sleep
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            autocal_select_out <= AUTOCAL_RESET;
        end else if (soft_rst || state == SFPC_SLEEP) begin
            autocal_select_out <= AUTOCAL_RESET;
        end else if (autocal_write_in) begin
            autocal_select_out <= synth_autocal_select_in;
        end
    end

    // index limit, lost in sleep like every setting
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            power_index_limit <= PIDX_RESET;
        end else if (soft_rst || state == SFPC_SLEEP) begin
            power_index_limit <= PIDX_RESET;
        end else if (power_index_write_in) begin
            power_index_limit <= power_index_limit_in;
        end
    end

    // table entries default after reset, written one at a time
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < TABLE_DEPTH; i++) power_level_table[i] <= PWR_RESET;
        end else if (soft_rst || state == SFPC_SLEEP) begin
            for (int i = 0; i < TABLE_DEPTH; i++) power_level_table[i] <= PWR_RESET;
        end else if (table_write_in) begin
            power_level_table[table_addr_in] <= table_data_in;
        end
    end

    // power-down armed by strobe, taken when chip select rises
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pd_armed <= 1'b0;
        end else if (state == SFPC_SLEEP) begin
            pd_armed <= 1'b0;
        end else if (power_down_strobe_in && !chip_select_n_in) begin
            pd_armed <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state      <= SFPC_IDLE;
            cal_cnt    <= '0;
            tx_off_cnt <= 2'h0;
        end else if (soft_rst) begin
            state      <= SFPC_IDLE;
            cal_cnt    <= '0;
            tx_off_cnt <= 2'h0;
        end else begin
            case (state)
                SFPC_SLEEP: begin
                    // chip select low wakes the core
                    if (!chip_select_n_in) state <= SFPC_IDLE;
                end
                SFPC_IDLE: begin
                    cal_cnt <= '0;
                    if (pd_armed && chip_select_n_in) begin
                        state <= SFPC_SLEEP;
                    end else if (calibrate_strobe_in) begin
                        state <= SFPC_CAL_MAN;
                    end else if (tx_strobe_in) begin
                        state <= (autocal_select_out == AUTOCAL_ON) ? SFPC_CAL_ON : SFPC_TX;
                    end
                end
                SFPC_CAL_ON: begin
                    cal_cnt <= cal_done ? '0 : cal_cnt + 1'b1;
                    if (cal_done) state <= SFPC_TX;
                end
                SFPC_TX: begin
                    if (packet_end_in || idle_strobe_in) state <= SFPC_RAMP_DN;
                end
                SFPC_RAMP_DN: begin
                    // wait until shaping index reaches zero or an idle strobe arrives
                    if (shape_idx == '0 || idle_strobe_in) begin
                        tx_off_cnt <= tx_off_cnt + 1'b1;
                        // calibrate on switch-off or every fourth
                        if (autocal_select_out == AUTOCAL_OFF ||
                            (autocal_select_out == AUTOCAL_OFF4 && tx_off_cnt == 2'h3))
                            state <= SFPC_CAL_OFF;
                        else
                            state <= SFPC_IDLE;
                    end
                end
                SFPC_CAL_OFF, SFPC_CAL_MAN: begin
                    cal_cnt <= cal_done ? '0 : cal_cnt + 1'b1;
                    if (cal_done) state <= SFPC_IDLE;
                end
                default: state <= SFPC_IDLE;
            endcase
        end
    end

    // calibration lost in sleep and at reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            calibrated_out <= 1'b0;
        end else if (soft_rst || state == SFPC_SLEEP) begin
            calibrated_out <= 1'b0;
        end else if (is_cal(state) && cal_done) begin
            calibrated_out <= 1'b1;
        end
    end

    // ==========================================================
    // shaping tick: eight per symbol
    // divider period is symbol period over eight, from the host
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (tick_cnt >= shape_tick_div_in) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick     <= 1'b0;
        end
    end

    // ==========================================================
    // shaping counter
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            shape_idx <= '0;
        end else if (state != SFPC_TX && state != SFPC_RAMP_DN) begin
            shape_idx <= '0;
        end else if (shape_idx > power_index_limit) begin
            // limit lowered mid-packet: clamp at once
            shape_idx <= power_index_limit;
        end else if (tick) begin
            if (state == SFPC_RAMP_DN || (ask_mode_in && !symbol_in)) begin
                if (shape_idx != '0) shape_idx <= shape_idx - 1'b1;
            end else if (shape_idx != power_index_limit) begin
                shape_idx <= shape_idx + 1'b1;
            end
        end
    end

    // ==========================================================
    // registered outputs
    // ready follows chip select, held high while asleep
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            chip_ready_n_out <= 1'b1;
            core_power_out   <= 1'b0;
        end else begin
            chip_ready_n_out <= chip_select_n_in || state == SFPC_SLEEP;
            core_power_out   <= state != SFPC_SLEEP;
        end
    end

    // state flags, one cycle behind the state register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            synth_on_out    <= 1'b0;
            calibrating_out <= 1'b0;
            pa_on_out       <= 1'b0;
        end else begin
            synth_on_out    <= state == SFPC_CAL_ON || state == SFPC_TX ||
                               state == SFPC_RAMP_DN;
            calibrating_out <= is_cal(state);
            pa_on_out       <= state == SFPC_TX || state == SFPC_RAMP_DN;
        end
    end

    // word formed continuously; host keeps inputs still while running
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            synth_base_frequency_word_word_out <= '0;
        end else begin
            synth_base_frequency_word_word_out <= base_frequency_word_word(base_frequency_word, channel_number_in,
                                             spacing_mantissa_in, spacing_exponent_in);
        end
    end

    // counter indexes the table; index and level leave together
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pa_index_out <= '0;
            pa_level_out <= PWR_RESET;
        end else begin
            pa_index_out <= shape_idx;
            pa_level_out <= power_level_table[shape_idx];
        end
    end
endmodule

// ---- tb/sfpc_chk.sv ----
// concurrent checks on the synthesizer and pa control ports
`timescale 1ns/100ps
module sfpc_chk
    import sfpc_pkg::*;
(
    input wire logic                clk_in,
    input wire logic                rst_in,
    input wire logic                chip_select_n_in,
    input wire logic                calibrate_strobe_in,
    input wire logic                tx_strobe_in,
    input wire logic                power_index_write_in,
    input wire logic [PIDX_W-1:0]   power_index_limit_in,
    input wire logic [7:0]          base_base_frequency_word_high_byte_in,
    input wire logic [7:0]          base_base_frequency_word_mid_byte_in,
    input wire logic [7:0]          base_base_frequency_word_low_byte_in,
    input wire logic [CHAN_W-1:0]   channel_number_in,
    input wire logic [MANT_W-1:0]   spacing_mantissa_in,
    input wire logic [EXP_W-1:0]    spacing_exponent_in,
    input wire logic                ask_mode_in,
    input wire logic                symbol_in,
    input wire logic                chip_ready_n_out,
    input wire logic                synth_on_out,
    input wire logic                calibrating_out,
    input wire logic                pa_on_out,
    input wire logic [BASE_W-1:0]   synth_base_frequency_word_word_out,
    input wire logic [PIDX_W-1:0]   pa_index_out,
    input wire logic [PWR_W-1:0]    pa_level_out,
    input wire logic [1:0]          autocal_select_out
);
    // ====================
    // helper logic
    logic [31:0]        want;
    logic [PIDX_W-1:0]  lim;
    logic [PIDX_W-1:0]  lim_q;
    logic [15:0]        cal_len;
    // kept wide so truncation happens only at the end
    assign want = {8'h00, base_base_frequency_word_high_byte_in, base_base_frequency_word_mid_byte_in, base_base_frequency_word_low_byte_in}
        + ((((32'h100 + spacing_mantissa_in) << spacing_exponent_in) * channel_number_in) >> 2);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lim   <= PIDX_RESET;
            lim_q <= PIDX_RESET;
        end else begin
            lim   <= power_index_write_in ? power_index_limit_in : lim;
            lim_q <= lim;
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cal_len <= 16'h0000;
        end else begin
            cal_len <= calibrating_out ? cal_len + 16'h0001 : 16'h0000;
        end
    end
    // ====================
    // properties
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_idle_cal;
        calibrate_strobe_in && !synth_on_out && !calibrating_out && !pa_on_out
            && !chip_select_n_in && !chip_ready_n_out && $past(!tx_strobe_in && !calibrate_strobe_in);
    endsequence
    AST_BASE_FREQUENCY_WORD_WORD: assert property (1'b1 |=> synth_base_frequency_word_word_out == $past(want[23:0]))
        else $error("frequency word differs from base plus channel step");
    AST_CAL_MAN: assert property (s_idle_cal |-> ##2 calibrating_out)
        else $error("calibrate strobe in idle did not start calibration");
    AST_CAL_LEN: assert property ($fell(calibrating_out) |-> cal_len == CAL_CYCLES)
        else $error("calibration length wrong");
    AST_AUTOCAL_RESET: assert property ($fell(rst_in) |-> autocal_select_out == AUTOCAL_RESET)
        else $error("autocal selection not at reset value");
    AST_LEVEL_RESET: assert property ($fell(rst_in) |-> pa_level_out == PWR_RESET ##1 pa_level_out == PWR_RESET)
        else $error("power level not at reset value");
    AST_INDEX_LIMIT: assert property (lim == lim_q |-> pa_index_out <= lim)
        else $error("power index above limit");
    AST_SHAPE_STEP: assert property (pa_on_out && $past(pa_on_out) && ask_mode_in && lim == lim_q
            && $stable(symbol_in) && symbol_in == $past(symbol_in, 2) && $changed(pa_index_out)
            |-> pa_index_out == $past(pa_index_out) + (symbol_in ? 3'h1 : 3'h7))
        else $error("shaping index did not follow symbol");
    AST_READY: assert property (chip_select_n_in |=> chip_ready_n_out)
        else $error("ready shown while chip select high");
endmodule
bind sfpc_core sfpc_chk u_chk (
    .clk_in(clk_in), .rst_in(rst_in), .chip_select_n_in(chip_select_n_in),
    .calibrate_strobe_in(calibrate_strobe_in), .tx_strobe_in(tx_strobe_in),
    .power_index_write_in(power_index_write_in), .power_index_limit_in(power_index_limit_in),
    .base_base_frequency_word_high_byte_in(base_base_frequency_word_high_byte_in), .base_base_frequency_word_mid_byte_in(base_base_frequency_word_mid_byte_in),
    .base_base_frequency_word_low_byte_in(base_base_frequency_word_low_byte_in), .channel_number_in(channel_number_in),
    .spacing_mantissa_in(spacing_mantissa_in), .spacing_exponent_in(spacing_exponent_in),
    .ask_mode_in(ask_mode_in), .symbol_in(symbol_in), .chip_ready_n_out(chip_ready_n_out),
    .synth_on_out(synth_on_out), .calibrating_out(calibrating_out), .pa_on_out(pa_on_out),
    .synth_base_frequency_word_word_out(synth_base_frequency_word_word_out), .pa_index_out(pa_index_out),
    .pa_level_out(pa_level_out), .autocal_select_out(autocal_select_out));

// ---- tb/sfpc_host.sv ----
// host model: chip select and command strobes toward the block
`timescale 1ns/100ps
module sfpc_host (
    input  wire logic   clk_in,
    input  wire logic   chip_ready_n_in,
    output logic        chip_select_n_out,
    output logic [5:0]  strobe_out
);
    // strobes: 0 reset, 1 power down, 2 calibrate, 3 tx, 4 idle, 5 packet end
    initial begin
        chip_select_n_out = 1'b1;
        strobe_out        = 6'h00;
    end
    task automatic select(input logic n);
        @(posedge clk_in);
        #1;
        chip_select_n_out = n;
    endtask
    task automatic power_up();
        select(1'b0);
        strobe(0);
    endtask
    task automatic strobe(input int k);
        int i;
        @(posedge clk_in);
        #1;
        for (i = 0; i < 200 && chip_ready_n_in !== 1'b0; i++) begin
            @(posedge clk_in);
            #1;
        end
        strobe_out[k] = 1'b1;
        @(posedge clk_in);
        #1;
        strobe_out[k] = 1'b0;
    endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the synthesizer and pa control block
`timescale 1ns/100ps
module tb;
    import sfpc_pkg::*;
    logic        clk, rst, cs_n, acal_wr, lim_wr, tw, ask, sym, rdy_n, pwr, son, cal, caled, paon;
    logic [5:0]  stb;
    logic [7:0]  hi, mid, lo, chan, mant, tdata, plev;
    logic [1:0]  expo, acal, asel;
    logic [2:0]  lim, taddr, pidx, last;
    logic [15:0] div;
    logic [23:0] word;
    int          fail_count, comparisons, c, n;
    sfpc_host host (.clk_in(clk), .chip_ready_n_in(rdy_n), .chip_select_n_out(cs_n), .strobe_out(stb));
    sfpc_core dut (
        .clk_in(clk), .rst_in(rst), .chip_select_n_in(cs_n), .soft_reset_strobe_in(stb[0]),
        .power_down_strobe_in(stb[1]), .calibrate_strobe_in(stb[2]), .tx_strobe_in(stb[3]),
        .idle_strobe_in(stb[4]), .packet_end_in(stb[5]),
        .base_base_frequency_word_high_byte_in(hi), .base_base_frequency_word_mid_byte_in(mid), .base_base_frequency_word_low_byte_in(lo),
        .channel_number_in(chan), .spacing_mantissa_in(mant), .spacing_exponent_in(expo),
        .synth_autocal_select_in(acal), .autocal_write_in(acal_wr), .power_index_limit_in(lim),
        .power_index_write_in(lim_wr), .table_write_in(tw), .table_addr_in(taddr),
        .table_data_in(tdata), .ask_mode_in(ask), .symbol_in(sym), .shape_tick_div_in(div),
        .chip_ready_n_out(rdy_n), .core_power_out(pwr), .synth_on_out(son), .calibrating_out(cal),
        .calibrated_out(caled), .pa_on_out(paon), .synth_base_frequency_word_word_out(word), .pa_index_out(pidx),
        .pa_level_out(plev), .autocal_select_out(asel));
    // ====================
    // shared tasks
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] want);
        comparisons++;
        if (seen !== want) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask
    // k: 0 autocal, 1 index limit, 2 table entry at taddr
    task automatic cfg(input int k, input logic [7:0] v);
        tick();
        {acal, lim, tdata} = {v[1:0], v[2:0], v};
        {acal_wr, lim_wr, tw} = 3'(3'b100 >> k);
        tick();
        {acal_wr, lim_wr, tw} = 3'h0;
    endtask
    task automatic wait_lvl(ref logic s, input logic v, input int lim_c);
        for (c = 0; c < lim_c && s !== v; c++) tick();
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ====================
    // scenarios
    task automatic t_reset();
        check("autocal", asel, AUTOCAL_ON);
        check("level", plev, PWR_RESET);
        host.power_up();
        for (int k = 0; k < 4; k++) begin
            cfg(0, 8'(k));
            tick();
            check("autocal code", asel, 24'(k));
        end
    endtask
    task automatic t_base_frequency_word();
        {hi, mid, lo, chan, mant} = 40'hFFFFF0FFFF;
        for (int e = 0; e < 4; e++) begin
            expo = 2'(e);
            repeat (2) tick();
            check("base_frequency_word word", word, 24'hFFFFF0 + ((((32'h1FF) << e) * 32'hFF) >> 2));
        end
        chan = 8'h00;
        repeat (2) tick();
        check("base_frequency_word word", word, 24'hFFFFF0);
        {hi, mid, lo, chan, mant, expo} = {40'h1234560100, 2'h2};
        repeat (2) tick();
        check("base_frequency_word word", word, 24'h123556);
    endtask
    task automatic t_man_cal();
        cfg(0, 8'(AUTOCAL_NEVER));
        host.strobe(2);
        wait_lvl(cal, 1'b1, 4);
        check("manual cal", cal, 1'b1);
        wait_lvl(cal, 1'b0, 20000);
        check("cal length", 24'(c), 24'(CAL_CYCLES));
        check("calibrated", caled, 1'b1);
    endtask
    task automatic t_tx();
        for (int a = 0; a < 8; a++) begin
            taddr = 3'(a);
            cfg(2, 8'h10 + 8'(a));
        end
        cfg(0, 8'(AUTOCAL_ON));
        cfg(1, 8'h03);
        host.strobe(3);
        wait_lvl(cal, 1'b1, 4);
        check("cal at switch-on", cal, 1'b1);
        wait_lvl(paon, 1'b1, 20000);
        check("synth on", son, 1'b1);
        for (c = 0; c < 200 && pidx !== 3'h3; c++) tick();
        check("ramp top level", plev, 8'h13);
        host.strobe(5);
        for (c = 0; c < 200 && paon === 1'b1; c++) begin
            last = pidx;
            tick();
        end
        check("index at pa off", last, 3'h0);
        cfg(0, 8'(AUTOCAL_OFF));
        host.strobe(3);
        wait_lvl(paon, 1'b1, 50);
        check("no cal at switch-on", cal, 1'b0);
        host.strobe(4);
        wait_lvl(cal, 1'b1, 20);
        check("cal at switch-off", cal, 1'b1);
        wait_lvl(cal, 1'b0, 20000);
    endtask
    task automatic t_ask();
        cfg(0, 8'(AUTOCAL_NEVER));
        div = 16'h0001;
        cfg(1, 8'h07);
        {ask, sym, n} = {2'b11, 32'd0};
        host.strobe(3);
        for (c = 0; c < 300 && pidx !== 3'h7; c++) begin
            n += (pidx === 3'h2);
            tick();
        end
        check("shape tick span", 24'(n), 24'(div) + 24'h1);
        repeat (16) tick();
        check("shape top", pidx, 3'h7);
        sym = 1'b0;
        for (c = 0; c < 300 && pidx !== 3'h0; c++) tick();
        repeat (16) tick();
        check("shape bottom", plev, 8'h10);
        host.strobe(4);
        ask = 1'b0;
        cfg(1, 8'h00);
        host.strobe(3);
        wait_lvl(paon, 1'b1, 50);
        repeat (16) tick();
        check("limit zero index", pidx, 3'h0);
        host.strobe(4);
    endtask
    task automatic t_sleep();
        host.strobe(1);
        host.select(1'b1);
        repeat (4) tick();
        check("sleep power", pwr, 1'b0);
        host.select(1'b0);
        wait_lvl(rdy_n, 1'b0, 200);
        check("wake power", pwr, 1'b1);
        check("settings lost", asel, AUTOCAL_ON);
    endtask
    // ====================
    // clock, reset, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rst, acal_wr, lim_wr, tw, ask, sym} = 6'h20;
        {hi, mid, lo, chan, mant, expo, acal, lim, taddr, tdata} = '0;
        div = 16'h0003;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        tick();
        t_reset();
        t_base_frequency_word();
        t_man_cal();
        t_tx();
        t_ask();
        t_sleep();
        results();
    end
    // full run needs about 60000 cycles
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        results();
    end
endmodule
